// File: logic/pcs_mgmt_regs.sv
// pcs_mgmt_regs: receive error counter and control/status register behind the mdio port.
// assumes mdc, mdio and the tristate pin are asynchronous pins; status and event inputs
// come from phy logic on clk_in.
`timescale 1ns/1ps
`default_nettype none
module pcs_mgmt_regs
    import pcs_pkg::*;
#(
    parameter int STRETCH_CYCLES = PCS_STRETCH_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic [4:0] phy_address_in,
    input wire logic rx_dv_in,
    input wire logic rx_err_in,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic tx_activity_in,
    input wire logic rx_activity_in,
    input wire logic link_up_in,
    input wire logic collision_in,
    input wire logic tx_pair_tristate_pin_in,
    output logic tx_pair_hiz_out,
    output logic counter_saturate_select_out,
    output logic irq_enable_out,
    output logic [PCS_LED_COUNT-1:0] led_out,
    output logic [PCS_LED_COUNT-1:0] led_oe_out
);
    // led index order: 5 rx, 4 tx/activity, 3 link, 2 collision, 1 full duplex, 0 speed
    pcs_csr_s csr;
    logic [15:0] err_count;
    logic err_seen;
    logic [1:0] mdc_sync, mdio_sync, tri_sync;
    logic [4:0] addr_sync1, addr_sync2;
    logic mdc_last;
    pcs_mgmt_state_e state;
    logic [5:0] ones;
    logic [4:0] bit_cnt;
    logic [11:0] hdr_shift;
    logic [15:0] data_shift;
    logic op_read, op_write;
    logic [4:0] reg_sel;
    logic rise, hdr_done, addr_hit, cor_clear, err_inc, wr_commit;
    logic [12:0] hdr;
    logic [15:0] wr_word;
    logic [PCS_LED_COUNT-1:0] led_event;

    // two flops on every pin; only the second stage is read by logic
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mdc_sync <= '0;
            mdio_sync <= '0;
            tri_sync <= '0;
            addr_sync1 <= '0;
            addr_sync2 <= '0;
            mdc_last <= 1'b0;
        end else begin
            mdc_sync <= {mdc_sync[0], mdc_in};
            mdio_sync <= {mdio_sync[0], mdio_in};
            tri_sync <= {tri_sync[0], tx_pair_tristate_pin_in};
            addr_sync1 <= phy_address_in;
            addr_sync2 <= addr_sync1;
            mdc_last <= mdc_sync[1];
        end
    end

    // frame decode helpers
    assign rise = mdc_sync[1] && !mdc_last;
    assign hdr = {hdr_shift, mdio_sync[1]};
    assign hdr_done = rise && state == PCS_ST_HDR && bit_cnt == PCS_HDR_LAST;
    assign addr_hit = hdr[12] && hdr[9:5] == addr_sync2;
    assign cor_clear = hdr_done && addr_hit && hdr[11:10] == PCS_OP_READ
        && hdr[4:0] == PCS_REG_RX_ERR_COUNT;
    assign wr_word = {data_shift[14:0], mdio_sync[1]};
    assign wr_commit = rise && state == PCS_ST_WDATA && bit_cnt == PCS_DATA_LAST
        && op_write && reg_sel == PCS_REG_CTRL_STATUS;
    assign err_inc = rx_dv_in && rx_err_in && !err_seen;

    // per-packet error latch so a burst of bad symbols counts once
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            err_seen <= 1'b0;
        end else if (!rx_dv_in) begin
            err_seen <= 1'b0;
        end else if (rx_err_in) begin
            err_seen <= 1'b1;
        end
    end

    // error counter; an error in the clearing cycle was not in the read value, so it is kept
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            err_count <= PCS_COUNT_RESET;
        end else if (cor_clear) begin
            err_count <= {15'h0000, err_inc};
        end else if (err_inc) begin
            if (err_count != PCS_COUNT_MAX) begin
                err_count <= err_count + 16'h0001;
            end else if (!csr.counter_saturate_select) begin
                err_count <= PCS_COUNT_RESET;
            end
        end
    end

    // control/status register; speed and duplex track the phy, reserved stays zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            csr <= PCS_CSR_RESET;
        end else begin
            if (wr_commit) begin
                csr <= pcs_csr_s'((csr & ~PCS_CSR_WMASK) | (wr_word & PCS_CSR_WMASK));
            end
            csr.reserved <= 2'h0;
            csr.speed_100 <= speed_100_in;
            csr.full_duplex <= full_duplex_in;
        end
    end

    // management frame receiver and read driver, stepped on mdc rising edges
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= PCS_ST_PRE;
            ones <= '0;
            bit_cnt <= '0;
            hdr_shift <= '0;
            data_shift <= '0;
            op_read <= 1'b0;
            op_write <= 1'b0;
            reg_sel <= '0;
            mdio_out <= 1'b0;
            mdio_oe_out <= 1'b0;
        end else if (rise) begin
            case (state)
                PCS_ST_PRE: begin
                    if (mdio_sync[1]) begin
                        ones <= (ones == PCS_PREAMBLE_BITS) ? ones : ones + 6'h01;
                    end else begin
                        ones <= '0;
                        // start bit 0 accepted after full preamble, or after idle when suppressed
                        if (ones == PCS_PREAMBLE_BITS || (csr.preamble_suppress && ones != '0)) begin
                            state <= PCS_ST_HDR;
                            bit_cnt <= '0;
                        end
                    end
                end
                PCS_ST_HDR: begin
                    hdr_shift <= hdr[11:0];
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == PCS_HDR_LAST) begin
                        bit_cnt <= '0;
                        op_read <= addr_hit && hdr[11:10] == PCS_OP_READ;
                        op_write <= addr_hit && hdr[11:10] == PCS_OP_WRITE;
                        reg_sel <= hdr[4:0];
                        // unmapped registers read as zero
                        data_shift <= (hdr[4:0] == PCS_REG_RX_ERR_COUNT) ? err_count :
                            (hdr[4:0] == PCS_REG_CTRL_STATUS) ? 16'(csr) : 16'h0000;
                        state <= addr_hit ? PCS_ST_TA : PCS_ST_PRE;
                    end
                end
                PCS_ST_TA: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == '0) begin
                        mdio_oe_out <= op_read; // drive turnaround zero
                        mdio_out <= 1'b0;
                    end else begin
                        bit_cnt <= '0;
                        state <= op_read ? PCS_ST_RDATA : PCS_ST_WDATA;
                        mdio_out <= data_shift[15];
                        data_shift <= {data_shift[14:0], 1'b0};
                    end
                end
                PCS_ST_RDATA: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    mdio_out <= data_shift[15];
                    data_shift <= {data_shift[14:0], 1'b0};
                    if (bit_cnt == PCS_DATA_LAST) begin
                        mdio_oe_out <= 1'b0;
                        mdio_out <= 1'b0;
                        state <= PCS_ST_PRE;
                    end
                end
                PCS_ST_WDATA: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    data_shift <= wr_word;
                    if (bit_cnt == PCS_DATA_LAST) begin
                        state <= PCS_ST_PRE;
                    end
                end
                default: begin
                    state <= PCS_ST_PRE;
                    mdio_oe_out <= 1'b0;
                end
            endcase
        end
    end

    // pin-facing controls; tristate pin or bit both float the pair
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_pair_hiz_out <= 1'b0;
            counter_saturate_select_out <= 1'b0;
            irq_enable_out <= 1'b0;
            led_oe_out <= '0;
        end else begin
            tx_pair_hiz_out <= csr.tx_pair_tristate || tri_sync[1];
            counter_saturate_select_out <= csr.counter_saturate_select;
            irq_enable_out <= csr.irq_enable;
            led_oe_out <= ~csr.led_off;
        end
    end

    // raw led events; the shared led merges receive activity only when selected
    assign led_event = {rx_activity_in,
        tx_activity_in || (csr.activity_both && rx_activity_in),
        link_up_in, collision_in, full_duplex_in, speed_100_in};

    genvar led_i;
    generate
        for (led_i = 0; led_i < PCS_LED_COUNT; led_i++) begin : g_led
            pcs_led_stretch #(
                .STRETCH_CYCLES(STRETCH_CYCLES)
            ) u_stretch (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .event_in(led_event[led_i]),
                .bypass_in(csr.stretch_disable),
                .led_out(led_out[led_i])
            );
        end
    endgenerate

    chk_count_once: assert property (@(posedge clk_in) disable iff (reset_in)
        (rx_dv_in && err_seen && !cor_clear) |=> err_count == $past(err_count))
        else $error("counter moved twice in one packet");
    chk_count_incr: assert property (@(posedge clk_in) disable iff (reset_in)
        (err_inc && !cor_clear && err_count != 16'hffff) |=> err_count == $past(err_count) + 16'h0001)
        else $error("counter did not advance by one");
    chk_read_clears: assert property (@(posedge clk_in) disable iff (reset_in)
        (cor_clear && !err_inc) |=> err_count == 16'h0000)
        else $error("clearing read left a count");
    chk_clear_keeps: assert property (@(posedge clk_in) disable iff (reset_in)
        (cor_clear && err_inc) |=> err_count == 16'h0001)
        else $error("error lost on clearing read");
    chk_sat_holds: assert property (@(posedge clk_in) disable iff (reset_in)
        (csr.counter_saturate_select && err_count == 16'hffff && !cor_clear) |=> err_count == 16'hffff)
        else $error("saturating counter left ffff");
    chk_wrap_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (!csr.counter_saturate_select && err_count == 16'hffff && err_inc && !cor_clear) |=> err_count == 16'h0000)
        else $error("counter did not wrap");
    chk_pin_tristate: assert property (@(posedge clk_in) disable iff (reset_in)
        tri_sync[1] |=> tx_pair_hiz_out)
        else $error("tristate pin ignored");
    chk_irq_reset: assert property (@(posedge clk_in)
        reset_in |=> !irq_enable_out && !csr.irq_enable)
        else $error("interrupt enable set after reset");
    chk_short_preamble: assert property (@(posedge clk_in) disable iff (reset_in)
        (rise && state == PCS_ST_PRE && !mdio_sync[1] && ones != 6'h20 && !csr.preamble_suppress)
        |=> state == PCS_ST_PRE)
        else $error("frame taken without preamble");
    chk_speed_track: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 csr.speed_100 == $past(speed_100_in) && csr.full_duplex == $past(full_duplex_in))
        else $error("speed or duplex status stale");
    chk_led_float: assert property (@(posedge clk_in) disable iff (reset_in)
        csr.led_off[5] |=> !led_oe_out[5])
        else $error("receive led driven while off");
    chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 csr.reserved == 2'h0)
        else $error("reserved bits not zero");
    chk_ta_drive: assert property (@(posedge clk_in) disable iff (reset_in)
        (rise && state == PCS_ST_TA && bit_cnt == 5'h00 && op_read) |=> mdio_oe_out && !mdio_out)
        else $error("turnaround zero not driven");
endmodule : pcs_mgmt_regs
`default_nettype wire

// File: logic/pcs_pkg.sv
// pcs_pkg: constants, states and carrier types of the management register block.
// assumes a 100 MHz device clock and a management master toggling mdc far slower.
package pcs_pkg;
    // management register addresses
    localparam logic [4:0] PCS_REG_RX_ERR_COUNT = 5'h15;
    localparam logic [4:0] PCS_REG_CTRL_STATUS = 5'h17;
    // management frame layout
    localparam logic [1:0] PCS_OP_READ = 2'h2;
    localparam logic [1:0] PCS_OP_WRITE = 2'h1;
    localparam logic [5:0] PCS_PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] PCS_HDR_LAST = 5'h0c;
    localparam logic [4:0] PCS_DATA_LAST = 5'h0f;
    // writable bits of the control/status word (speed, duplex, reserved excluded)
    localparam logic [15:0] PCS_CSR_WMASK = 16'h3cff;
    localparam logic [15:0] PCS_COUNT_MAX = 16'hffff;
    localparam logic [15:0] PCS_COUNT_RESET = 16'h0000;
    // led stretch: 48 ms least, 72 ms most, at the device clock
    localparam int PCS_STRETCH_MIN_MS = 48;
    localparam int PCS_STRETCH_MAX_MS = 72;
    localparam int PCS_CLK_KHZ = 100000;
    localparam int PCS_STRETCH_CYCLES = PCS_STRETCH_MIN_MS * PCS_CLK_KHZ;
    localparam int PCS_STRETCH_W = 23;
    localparam int PCS_LED_COUNT = 6;

    typedef enum logic [2:0] {
        PCS_ST_PRE = 3'b000,
        PCS_ST_HDR = 3'b001,
        PCS_ST_TA = 3'b010,
        PCS_ST_RDATA = 3'b011,
        PCS_ST_WDATA = 3'b100
    } pcs_mgmt_state_e;

    // control/status word as seen by management, msb first
    typedef struct packed {
        logic [1:0] reserved;
        logic counter_saturate_select;
        logic tx_pair_tristate;
        logic irq_enable;
        logic preamble_suppress;
        logic speed_100;
        logic full_duplex;
        logic activity_both;
        logic [5:0] led_off; // rx, tx/activity, link, collision, full duplex, speed
        logic stretch_disable;
    } pcs_csr_s;

    localparam pcs_csr_s PCS_CSR_RESET = '0;
endpackage : pcs_pkg

// File: logic/pcs_led_stretch.sv
// pcs_led_stretch: one led channel, stretches short events to a visible pulse.
// assumes the raw event comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pcs_led_stretch
    import pcs_pkg::*;
#(
    parameter int STRETCH_CYCLES = PCS_STRETCH_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic event_in,
    input wire logic bypass_in,
    output logic led_out
);
    localparam logic [PCS_STRETCH_W-1:0] RELOAD = PCS_STRETCH_W'(STRETCH_CYCLES);
    logic [PCS_STRETCH_W-1:0] hold;

    // reload on every event so the pulse outlasts the last event by the least time
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold <= '0;
        end else if (event_in) begin
            hold <= RELOAD;
        end else if (hold != '0) begin
            hold <= hold - 1'b1;
        end
    end

    // bypass shows the raw event; otherwise event or running hold
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            led_out <= 1'b0;
        end else begin
            led_out <= bypass_in ? event_in : (event_in || hold != '0);
        end
    end

    chk_bypass_follows: assert property (@(posedge clk_in) disable iff (reset_in)
        bypass_in |=> led_out == $past(event_in))
        else $error("led does not follow raw event in bypass");
    chk_stretch_holds: assert property (@(posedge clk_in) disable iff (reset_in)
        (!bypass_in && event_in) ##1 !bypass_in |=> led_out)
        else $error("stretched led dropped too early");
endmodule : pcs_led_stretch
`default_nettype wire

// File: verification/pcs_mdio_master.sv
// pcs_mdio_master: management station model, drives mdc and mdio frames.
// assumes the bench clock paces it; mdio has a pull-up, so a released line reads one.
`timescale 1ns/1ps
`default_nettype none
module pcs_mdio_master
    import pcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic dev_out_in,
    input wire logic dev_oe_in,
    output logic mdc_out,
    output logic mdio_line_out
);
    logic drv_en = 1'b0;
    logic drv_val = 1'b1;
    initial mdc_out = 1'b0;
    // wire level: device wins while it drives, then master, else the pull-up
    assign mdio_line_out = dev_oe_in ? dev_out_in : (drv_en ? drv_val : 1'b1);

    // one mdc period: bit set in the low phase, sampled late in the high phase
    task automatic bit_cycle(input logic en, input logic val, output logic smp);
        @(posedge clk_in) #1;
        mdc_out = 1'b0;
        drv_en = en;
        drv_val = val;
        repeat (8) @(posedge clk_in);
        #1 mdc_out = 1'b1;
        repeat (7) @(posedge clk_in);
        #1 smp = mdio_line_out;
    endtask : bit_cycle

    // whole frame; 18 periods after the header cover turnaround, data and the release
    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic [17:0] wv;
        logic [17:0] sh;
        logic s;
        hdr = {2'b01, op, phy, rg};
        wv = {2'b10, wd};
        sh = '0;
        for (int i = 0; i < pre; i++) begin
            bit_cycle(1'b1, 1'b1, s);
        end
        for (int i = 13; i >= 0; i--) begin
            bit_cycle(1'b1, hdr[i], s);
        end
        // a read leaves the line to the device, which answers one period early
        for (int j = 17; j >= 0; j--) begin
            bit_cycle(op == PCS_OP_WRITE, wv[j], s);
            sh = {sh[16:0], s};
        end
        rd = sh[16:1];
        // the clock stands still between frames
        @(posedge clk_in) #1;
        drv_en = 1'b0;
        mdc_out = 1'b0;
    endtask : frame
endmodule : pcs_mdio_master
`default_nettype wire

// File: verification/tb_phy_ctrl_status_rx_err_count.sv
// tb_phy_ctrl_status_rx_err_count: self-checking bench of the management register block.
// assumes a 100 MHz clock, the station model on mdio and a short led stretch.
`timescale 1ns/1ps
`default_nettype none
module tb_phy_ctrl_status_rx_err_count
    import pcs_pkg::*;
;
    localparam logic [4:0] PHY_ADDR = 5'h05;
    logic clk_in, reset_in, mdc, mdio_line, mdio_out, mdio_oe, rx_dv, rx_err, tp_pin;
    logic hiz, sat, irq;
    logic [5:0] ev, led, led_oe;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    pcs_mdio_master pcs_mdio_master_i (.clk_in(clk_in), .dev_out_in(mdio_out), .dev_oe_in(mdio_oe),
        .mdc_out(mdc), .mdio_line_out(mdio_line));
    pcs_mgmt_regs #(.STRETCH_CYCLES(20)) pcs_mgmt_regs_i (.clk_in(clk_in), .reset_in(reset_in),
        .mdc_in(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe),
        .phy_address_in(PHY_ADDR), .rx_dv_in(rx_dv), .rx_err_in(rx_err), .speed_100_in(ev[0]),
        .full_duplex_in(ev[1]), .tx_activity_in(ev[4]), .rx_activity_in(ev[5]), .link_up_in(ev[3]),
        .collision_in(ev[2]), .tx_pair_tristate_pin_in(tp_pin), .tx_pair_hiz_out(hiz),
        .counter_saturate_select_out(sat), .irq_enable_out(irq), .led_out(led), .led_oe_out(led_oe));

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] junk;
        pcs_mdio_master_i.frame(32, PCS_OP_WRITE, PHY_ADDR, rg, d, junk);
        repeat (8) @(posedge clk_in);
    endtask : wr

    task automatic rdc(input int pre, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] exp, input string what);
        logic [15:0] v;
        pcs_mdio_master_i.frame(pre, PCS_OP_READ, phy, rg, 16'h0000, v);
        chk(what, exp, v);
    endtask : rdc

    // one-cycle raw event, then the bench is 1 ns past the registering edge
    task automatic pulse(input logic [5:0] e);
        @(posedge clk_in) #1 ev = e;
        @(posedge clk_in) #1 ev = 6'h00;
    endtask : pulse

    task automatic t_reset();
        chk("led_oe", 16'h003f, {10'h000, led_oe});
        chk("out flags", 16'h0000, {13'h0000, hiz, sat, irq});
        rdc(32, PHY_ADDR, PCS_REG_RX_ERR_COUNT, 16'h0000, "count reset");
        rdc(32, PHY_ADDR, PCS_REG_CTRL_STATUS, 16'h0000, "csr reset");
    endtask : t_reset

    // three packets with two error symbols each count three, then the read clears
    task automatic t_count();
        for (int p = 0; p < 3; p++) begin
            @(posedge clk_in) #1 rx_dv = 1'b1;
            rx_err = 1'b1;
            @(posedge clk_in) #1 rx_err = 1'b0;
            @(posedge clk_in) #1 rx_err = 1'b1;
            @(posedge clk_in) #1 rx_dv = 1'b0;
            rx_err = 1'b0;
            repeat (2) @(posedge clk_in);
        end
        wr(PCS_REG_RX_ERR_COUNT, 16'h1234);
        rdc(32, PHY_ADDR, PCS_REG_RX_ERR_COUNT, 16'h0003, "count");
        rdc(32, PHY_ADDR, PCS_REG_RX_ERR_COUNT, 16'h0000, "count cleared");
    endtask : t_count

    // errored packets every other cycle across a clearing read; read plus remainder is the total
    // run at both phases so one of them lands an error on the clearing cycle itself
    task automatic t_cor_race(input int lead);
        logic [15:0] v1;
        logic [15:0] v2;
        fork
            begin
                repeat (lead) @(posedge clk_in);
                for (int p = 0; p < 800; p++) begin
                    @(posedge clk_in) #1 rx_dv = 1'b1;
                    rx_err = 1'b1;
                    @(posedge clk_in) #1 rx_dv = 1'b0;
                    rx_err = 1'b0;
                end
            end
            pcs_mdio_master_i.frame(32, PCS_OP_READ, PHY_ADDR, PCS_REG_RX_ERR_COUNT, 16'h0000, v1);
        join
        pcs_mdio_master_i.frame(32, PCS_OP_READ, PHY_ADDR, PCS_REG_RX_ERR_COUNT, 16'h0000, v2);
        chk("count kept", 16'h0320, v1 + v2);
    endtask : t_cor_race

    task automatic t_csr();
        @(posedge clk_in) #1 ev = 6'h03;
        wr(PCS_REG_CTRL_STATUS, 16'hffff);
        rdc(32, PHY_ADDR, PCS_REG_CTRL_STATUS, PCS_CSR_WMASK | 16'h0300, "csr all");
        chk("flags", 16'h0007, {13'h0000, hiz, sat, irq});
        chk("led_oe off", 16'h0000, {10'h000, led_oe});
        @(posedge clk_in) #1 ev = 6'h01;
        wr(PCS_REG_CTRL_STATUS, 16'h0000);
        rdc(32, PHY_ADDR, PCS_REG_CTRL_STATUS, 16'h0200, "speed only");
        chk("hiz idle", 16'h0000, {15'h0000, hiz});
        tp_pin = 1'b1;
        repeat (6) @(posedge clk_in);
        #1 chk("hiz pin", 16'h0001, {15'h0000, hiz});
        tp_pin = 1'b0;
        ev = 6'h00;
    endtask : t_csr

    // short preamble refused until suppression is on; a stranger's address is ignored
    task automatic t_preamble();
        rdc(1, PHY_ADDR, PCS_REG_CTRL_STATUS, 16'hffff, "short refused");
        rdc(32, PHY_ADDR + 5'h01, PCS_REG_CTRL_STATUS, 16'hffff, "other addr");
        wr(PCS_REG_CTRL_STATUS, 16'h0400);
        rdc(1, PHY_ADDR, PCS_REG_CTRL_STATUS, 16'h0400, "short taken");
    endtask : t_preamble

    task automatic t_led();
        wr(PCS_REG_CTRL_STATUS, 16'h0042);
        chk("led_oe rx sp off", 16'h001e, {10'h000, led_oe});
        wr(PCS_REG_CTRL_STATUS, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            pulse(6'h01 << k);
            chk("led raw", 16'h0001 << k, {10'h000, led});
            @(posedge clk_in) #1 chk("led raw off", 16'h0000, {10'h000, led});
        end
        wr(PCS_REG_CTRL_STATUS, 16'h0081);
        pulse(6'h20);
        chk("led rx both", 16'h0030, {10'h000, led});
        wr(PCS_REG_CTRL_STATUS, 16'h0000);
        pulse(6'h10);
        repeat (10) @(posedge clk_in);
        #1 chk("led stretched", 16'h0010, {10'h000, led});
        repeat (10) @(posedge clk_in);
        #1 chk("led stretch last", 16'h0010, {10'h000, led});
        @(posedge clk_in) #1 chk("led stretch end", 16'h0000, {10'h000, led});
    endtask : t_led

    // clock; the station model paces itself on it
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // hang guard: well above the roughly 22k cycles the scenarios need
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        reset_in = 1'b1;
        rx_dv = 1'b0;
        rx_err = 1'b0;
        tp_pin = 1'b0;
        ev = 6'h00;
        repeat (2) @(posedge clk_in);
        #1 reset_in = 1'b0;
        repeat (4) @(posedge clk_in);
        t_reset();
        t_count();
        t_cor_race(0);
        t_cor_race(1);
        t_csr();
        t_preamble();
        t_led();
        final_report();
    end
endmodule : tb_phy_ctrl_status_rx_err_count
`default_nettype wire
